// ==== dv/pic_cpu_model.sv ====
/*
  CPU sequencer model facing the interrupt controller: turns bench commands
  into instruction-end, mask and return pulses and trap requests held until taken.
  Assumes the controller runs on the same clock and answers as its contract says.
*/
`timescale 1ns/1ps
module pic_cpu_model (
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     resetn,
  // Bench commands: end_instr, swi, undef, ei, di, return_maskable
  input  wire logic [5:0]               cmd,
  // Controller side
  input  wire pic_pkg::pic_cpu_out_type cpu_out,
  output pic_pkg::pic_cpu_in_type       cpu_in
);
  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      cpu_in <= '0;
    end else begin
      cpu_in.sample          <= cmd[0];
      cpu_in.unmask_instr    <= cmd[3];
      cpu_in.mask_off_instr  <= cmd[4];
      cpu_in.ret_restore     <= cmd[5];
      // The stacked mask is what a return pops back
      cpu_in.ret_mask        <= cpu_out.push_mask;
      // Trap requests stay up until taken, as the opcode decoder would hold them
      cpu_in.soft_trap       <= (cpu_in.soft_trap | cmd[1]) & !cpu_out.soft_ack;
      cpu_in.bad_opcode_trap <= (cpu_in.bad_opcode_trap | cmd[2]) & !cpu_out.soft_ack;
    end
  end
endmodule

// ==== dv/prioritized_interrupt_controller_tb_top.sv ====
/*
  Self-checking bench of the interrupt controller: register access over
  Avalon-MM, request sources and acceptance sequences through the CPU model.
  Assumes the default machine cycle length of the package.
*/
`timescale 1ns/1ps
module prioritized_interrupt_controller_tb_top;
  localparam int unsigned MC = pic_pkg::MC_CLKS_DEF;
  logic                     clock     = 1'b0;
  logic                     resetn    = 1'b0;
  logic [5:0]               cmd       = 6'h00;
  pic_pkg::pic_av_req_type  av_req    = '0;
  pic_pkg::pic_src_type     src       = '0;
  pic_pkg::pic_av_rsp_type  av_rsp;
  pic_pkg::pic_cpu_in_type  cpu_in;
  pic_pkg::pic_cpu_out_type cpu_out;
  logic [7:0]               rd;
  int                       num_errors = 0;
  int                       n_tests    = 0;

  always #4 clock = ~clock;

  pic_ctrl #(.MC_CLKS(MC)) uut (
    .clock(clock), .resetn(resetn), .av_req(av_req), .av_rsp(av_rsp),
    .src(src), .cpu_in(cpu_in), .cpu_out(cpu_out));
  pic_cpu_model cpu (
    .clock(clock), .resetn(resetn), .cmd(cmd), .cpu_out(cpu_out), .cpu_in(cpu_in));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Holds the request until waitrequest is sampled low, then releases it
  task automatic bus(input logic wr, input logic [6:0] idx, input logic [7:0] wd);
    int n;
    @(posedge clock);
    av_req.read       <= !wr;
    av_req.write      <= wr;
    av_req.address    <= {idx, 2'b00};
    av_req.writedata  <= {24'h00_0000, wd};
    av_req.byteenable <= 4'hF;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (av_rsp.waitrequest !== 1'b0 && n < 50);
    rd = av_rsp.readdata[7:0];
    if (n >= 50) num_errors++;
    av_req.read  <= 1'b0;
    av_req.write <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [6:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    check(what, {8'h00, exp}, {8'h00, rd});
  endtask

  task automatic pulse(input int b);
    @(posedge clock);
    cmd[b] <= 1'b1;
    @(posedge clock);
    cmd[b] <= 1'b0;
  endtask

  task automatic fire(input pic_pkg::pic_src_type v);
    @(posedge clock);
    src <= v;
    @(posedge clock);
    src <= '0;
  endtask

  // Ends an instruction and follows the acceptance; index 0 expects none
  task automatic take(input logic [3:0] idx, input logic mask);
    int c;
    int np;
    int vat;
    pulse(0);
    c = 0;
    do begin
      @(posedge clock);
      c++;
    end while (cpu_out.accept !== 1'b1 && c < 12);
    check("accept", {15'h0000, idx != 4'h0}, {15'h0000, cpu_out.accept});
    if (idx == 4'h0) return;
    check("accept_idx", {12'h000, idx}, {12'h000, cpu_out.accept_idx});
    check("vector", 16'hFFFE - {11'h000, idx, 1'b0}, cpu_out.vector);
    check("push_mask", {15'h0000, mask}, {15'h0000, cpu_out.push_mask});
    check("soft_ack", {15'h0000, idx == 4'h1}, {15'h0000, cpu_out.soft_ack});
    np = 0;
    vat = 0;
    for (c = 1; c <= 8 * MC + 2; c++) begin
      @(posedge clock);
      if (cpu_out.push_valid === 1'b1) begin
        check("push_kind", 16'(np), 16'(cpu_out.push_kind));
        check("push time", 16'(MC * (np + 1)), 16'(c));
        np++;
      end
      if (cpu_out.vec_valid === 1'b1) vat = c;
    end
    check("pushes", 16'h0003, 16'(np));
    check("vector time", 16'(pic_pkg::ACC_MCYC * MC), 16'(vat));
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    rd_chk("enable low", pic_pkg::IDX_EN_LO, 8'h00);
    rd_chk("enable high", pic_pkg::IDX_EN_HI, 8'h00);
    rd_chk("pending low", pic_pkg::IDX_PEND_LO, 8'h00);
    rd_chk("pending high", pic_pkg::IDX_PEND_HI, 8'h00);
    rd_chk("unmapped", 7'h50, 8'h00);
    bus(1'b1, pic_pkg::IDX_EN_HI, 8'hFF);
    bus(1'b1, pic_pkg::IDX_EN_LO, 8'hFE);
    rd_chk("enable low", pic_pkg::IDX_EN_LO, 8'hF0);
    rd_chk("enable high", pic_pkg::IDX_EN_HI, 8'hFF);
    bus(1'b1, pic_pkg::IDX_SELECT, 8'h08);
    fire(pic_pkg::pic_src_type'(17'h0_0414));
    rd_chk("pending high", pic_pkg::IDX_PEND_HI, 8'h00);
    // Maskable sources only: a pending trap would be taken even while masked
    fire(pic_pkg::pic_src_type'(17'h1_FFFC));
    rd_chk("pending low", pic_pkg::IDX_PEND_LO, 8'hF0);
    rd_chk("pending high", pic_pkg::IDX_PEND_HI, 8'hFF);
    check("irq_req", 16'h0000, {15'h0000, cpu_out.irq_req});
    bus(1'b1, pic_pkg::IDX_PEND_LO, 8'hFF);
    rd_chk("pending low", pic_pkg::IDX_PEND_LO, 8'hF0);
    take(4'h0, 1'b0);
    pulse(3);
    rd_chk("enable low", pic_pkg::IDX_EN_LO, 8'hF1);
    fire(pic_pkg::pic_src_type'(17'h0_0003));
    take(4'h2, 1'b1);
    rd_chk("enable low", pic_pkg::IDX_EN_LO, 8'hF0);
    rd_chk("status", pic_pkg::IDX_STATUS, 8'h26);
    pulse(5);
    take(4'h3, 1'b1);
    pulse(5);
    for (int i = 4; i <= 15; i++) begin
      take(4'(i), 1'b1);
      pulse(5);
    end
    rd_chk("pending low", pic_pkg::IDX_PEND_LO, 8'h00);
    rd_chk("pending high", pic_pkg::IDX_PEND_HI, 8'h00);
    pulse(4);
    fire('1);
    bus(1'b1, pic_pkg::IDX_PEND_LO, 8'h0C);
    rd_chk("pending low", pic_pkg::IDX_PEND_LO, 8'h0C);
    bus(1'b1, pic_pkg::IDX_PEND_HI, 8'h00);
    rd_chk("pending high", pic_pkg::IDX_PEND_HI, 8'h00);
    pulse(1);
    take(4'h1, 1'b0);
    pulse(2);
    take(4'h1, 1'b0);
    take(4'h2, 1'b0);
    bus(1'b1, pic_pkg::IDX_SELECT, 8'h0F);
    fire(pic_pkg::pic_src_type'(17'h0_0414));
    rd_chk("pending high", pic_pkg::IDX_PEND_HI, 8'hC2);
    @(posedge clock);
    resetn <= 1'b0;
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    rd_chk("pending high", pic_pkg::IDX_PEND_HI, 8'h00);
    rd_chk("enable low", pic_pkg::IDX_EN_LO, 8'h00);
    close_out;
  end

  // A hang costs one mismatch and ends the run the normal way
  initial begin
    #100_000;
    num_errors++;
    close_out;
  end
endmodule

// ==== rtl/pic_ctrl.sv ====
/*
  Prioritized interrupt controller: pending latches, enable register, source
  selection, acceptance sequence and an Avalon-MM register slave.
  Assumes the CPU sequencer pulses sample in the last cycle of each
  instruction, holds the two trap requests until soft_ack, and that all
  request sources run on the same clock as this block.

*/
`timescale 1ns/1ps
module pic_ctrl #(
  parameter int unsigned MC_CLKS = pic_pkg::MC_CLKS_DEF
) (
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     resetn,
  // Register bus
  input  wire pic_pkg::pic_av_req_type  av_req,
  output pic_pkg::pic_av_rsp_type       av_rsp,
  // Request sources
  input  wire pic_pkg::pic_src_type     src,
  // CPU sequencer
  input  wire pic_pkg::pic_cpu_in_type  cpu_in,
  output pic_pkg::pic_cpu_out_type      cpu_out
);

  // ----------------------------------------------------------------
  // Parameters and checks
  // ----------------------------------------------------------------
  localparam int ACC_C = int'(pic_pkg::ACC_MCYC * MC_CLKS);
  localparam int MC_C  = int'(MC_CLKS);

  if (MC_CLKS < 1 || MC_CLKS > 255) begin : g_bad_mc
    $error("MC_CLKS must lie between 1 and 255");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  pic_pkg::pic_state_type st_r;
  pic_pkg::pic_state_type st_nxt;
  logic [15:0]            set_vec;
  logic [15:0]            clr_vec;
  logic [15:0]            en_n;
  logic [31:0]            rdata;
  logic [6:0]             reg_idx;
  logic                   av_on;
  logic                   av_wr;
  logic                   prio_valid;
  logic [3:0]             prio_idx;
  logic                   mask_q;
  logic [15:0]            pend_q;
  logic [15:0]            set_q;

  assign av_rsp  = st_r.av;
  assign cpu_out = st_r.cpu;

  // ----------------------------------------------------------------
  // Priority resolver
  // ----------------------------------------------------------------
  pic_prio u_prio (
    .pend     (st_r.pend),
    .en       (st_r.en),
    .ext0_en  (st_r.sel[pic_pkg::SEL_EXT0]),
    .soft_req (cpu_in.soft_trap | cpu_in.bad_opcode_trap),
    .valid    (prio_valid),
    .idx      (prio_idx)
  );

  // ----------------------------------------------------------------
  // Source to latch mapping
  // ----------------------------------------------------------------
  // Soft and bad-opcode traps have no latch: bits 1 and 0 stay zero
  always_comb begin
    set_vec     = 16'h0000;
    set_vec[2]  = src.address_trap;
    set_vec[3]  = src.watchdog_irq;
    set_vec[4]  = src.ext0;
    set_vec[5]  = src.ext1;
    set_vec[6]  = src.timebase;
    set_vec[7]  = src.ext2;
    set_vec[8]  = src.timer1;
    // An unselected source on a shared level is dropped, not held
    set_vec[9]  = st_r.sel[pic_pkg::SEL_L9]  ? src.sync_serial : src.uart_rx;
    set_vec[10] = src.uart_tx;
    set_vec[11] = src.timer4;
    set_vec[12] = src.timer6;
    set_vec[13] = src.converter_done;
    set_vec[14] = st_r.sel[pic_pkg::SEL_L14] ? src.timer3 : src.ext3;
    set_vec[15] = st_r.sel[pic_pkg::SEL_L15] ? src.timer5 : src.ext5;
  end

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  assign reg_idx = av_req.address[pic_pkg::AV_AW-1:2];
  assign av_on   = av_req.read | av_req.write;
  assign av_wr   = av_req.write && !st_r.av.waitrequest && av_req.byteenable[0];

  always_comb begin
    rdata = 32'h0000_0000;
    case (reg_idx)
      pic_pkg::IDX_EN_LO:   rdata[7:0] = st_r.en[7:0];
      pic_pkg::IDX_EN_HI:   rdata[7:0] = st_r.en[15:8];
      pic_pkg::IDX_PEND_LO: rdata[7:0] = st_r.pend[7:0];
      pic_pkg::IDX_PEND_HI: rdata[7:0] = st_r.pend[15:8];
      pic_pkg::IDX_SELECT:  rdata[3:0] = st_r.sel;
      pic_pkg::IDX_STATUS:  rdata[7:0] = {st_r.cpu.accept_idx, 1'b0, st_r.cpu.irq_req,
                                          st_r.saved_mask, st_r.fsm == pic_pkg::ST_ACCEPT};
      default:              rdata = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt                = st_r;
    st_nxt.cpu.accept     = 1'b0;
    st_nxt.cpu.soft_ack   = 1'b0;
    st_nxt.cpu.push_valid = 1'b0;
    st_nxt.cpu.vec_valid  = 1'b0;
    st_nxt.cpu.irq_req    = prio_valid;

    // Bus slave: one wait cycle, read data captured with the ready edge
    if (av_on && st_r.av.waitrequest) begin
      st_nxt.av.waitrequest = 1'b0;
      st_nxt.av.readdata    = rdata;
    end else begin
      st_nxt.av.waitrequest = 1'b1;
    end

    // Enable register: instructions, bus writes, then return restore
    en_n = st_r.en;
    if (cpu_in.unmask_instr) begin
      en_n[pic_pkg::MASK_BIT] = 1'b1;
    end
    if (cpu_in.mask_off_instr) begin
      en_n[pic_pkg::MASK_BIT] = 1'b0;
    end
    if (av_wr && reg_idx == pic_pkg::IDX_EN_LO) begin
      en_n[7:0] = av_req.writedata[7:0] & pic_pkg::EN_LO_WMASK;
    end
    if (av_wr && reg_idx == pic_pkg::IDX_EN_HI) begin
      en_n[15:8] = av_req.writedata[7:0];
    end
    if (cpu_in.ret_restore) begin
      en_n[pic_pkg::MASK_BIT] = cpu_in.ret_mask;
    end
    if (av_wr && reg_idx == pic_pkg::IDX_SELECT) begin
      st_nxt.sel = av_req.writedata[3:0];
    end

    // Latch clears: a zero written clears, a one leaves the latch alone
    clr_vec = 16'h0000;
    if (av_wr && reg_idx == pic_pkg::IDX_PEND_LO) begin
      clr_vec[7:0] = ~av_req.writedata[7:0];
    end
    if (av_wr && reg_idx == pic_pkg::IDX_PEND_HI) begin
      clr_vec[15:8] = ~av_req.writedata[7:0];
    end

    case (st_r.fsm)
      pic_pkg::ST_IDLE: begin
        // Only the last cycle of an instruction may start acceptance
        if (cpu_in.sample && prio_valid) begin
          st_nxt.fsm            = pic_pkg::ST_ACCEPT;
          st_nxt.sub            = 8'h00;
          st_nxt.mcyc           = 3'h0;
          st_nxt.saved_mask     = st_r.en[pic_pkg::MASK_BIT];
          st_nxt.cpu.push_mask  = st_r.en[pic_pkg::MASK_BIT];
          en_n[pic_pkg::MASK_BIT] = 1'b0;
          st_nxt.cpu.accept     = 1'b1;
          st_nxt.cpu.accept_idx = prio_idx;
          st_nxt.cpu.vector     = pic_pkg::pic_vector(prio_idx);
          st_nxt.cpu.soft_ack   = prio_idx == 4'(pic_pkg::SOFT_IDX);
          if (prio_idx >= 4'(pic_pkg::TRAP_IDX)) begin
            clr_vec[prio_idx] = 1'b1;
          end
        end
      end
      pic_pkg::ST_ACCEPT: begin
        // Eight machine cycles: three pushes, then the vector load
        if (st_r.sub == 8'(MC_CLKS - 1)) begin
          st_nxt.sub  = 8'h00;
          st_nxt.mcyc = st_r.mcyc + 3'h1;
          if (st_r.mcyc < 3'(pic_pkg::PUSH_COUNT)) begin
            st_nxt.cpu.push_valid = 1'b1;
            st_nxt.cpu.push_kind  = pic_pkg::pic_push_type'(st_r.mcyc[1:0]);
          end
          if (st_r.mcyc == 3'(pic_pkg::ACC_MCYC - 1)) begin
            st_nxt.cpu.vec_valid = 1'b1;
            st_nxt.fsm           = pic_pkg::ST_IDLE;
          end
        end else begin
          st_nxt.sub = st_r.sub + 8'h01;
        end
      end
      default: begin
        st_nxt.fsm = pic_pkg::ST_IDLE;
      end
    endcase

    st_nxt.en = en_n;
    // A request in the same cycle as its clear wins
    st_nxt.pend = ((st_r.pend & ~clr_vec) | set_vec) & pic_pkg::PEND_MASK;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      st_r                <= '0;
      st_r.fsm            <= pic_pkg::ST_IDLE;
      st_r.en             <= pic_pkg::EN_RESET;
      st_r.pend           <= pic_pkg::PEND_RESET;
      st_r.sel            <= pic_pkg::SEL_RESET;
      st_r.av.waitrequest <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  assign mask_q = st_r.en[pic_pkg::MASK_BIT];
  assign pend_q = st_r.pend;
  assign set_q  = set_vec;

  property p_reset_clear;
    @(posedge clock) !resetn |=> (pend_q == 16'h0000 && st_r.en == 16'h0000);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("reset left a latch or an enable set");

  property p_nmi_accept;
    @(posedge clock) disable iff (!resetn)
      (st_r.fsm == pic_pkg::ST_IDLE && cpu_in.sample && pend_q[3] && !mask_q)
      |=> st_r.cpu.accept;
  endproperty
  a_nmi_accept: assert property (p_nmi_accept)
    else $error("watchdog request not accepted while masked");

  property p_mask_gate;
    @(posedge clock) disable iff (!resetn)
      (st_r.cpu.accept && st_r.cpu.accept_idx >= 4'h4) |-> $past(mask_q);
  endproperty
  a_mask_gate: assert property (p_mask_gate)
    else $error("maskable request accepted with master mask low");

  property p_clear_accept;
    @(posedge clock) disable iff (!resetn)
      (st_r.cpu.accept && st_r.cpu.accept_idx >= 4'h2)
      |-> (pend_q & ~$past(set_q) & (16'h0001 << st_r.cpu.accept_idx)) == 16'h0000;
  endproperty
  a_clear_accept: assert property (p_clear_accept)
    else $error("accepted latch still set");

  property p_accept_len;
    @(posedge clock) disable iff (!resetn)
      st_r.cpu.accept |-> ##ACC_C st_r.cpu.vec_valid;
  endproperty
  a_accept_len: assert property (p_accept_len)
    else $error("vector load not at end of eighth machine cycle");

  property p_push_order;
    @(posedge clock) disable iff (!resetn)
      st_r.cpu.accept |->
        ##MC_C (st_r.cpu.push_valid && st_r.cpu.push_kind == pic_pkg::PUSH_PSW)
        ##MC_C (st_r.cpu.push_valid && st_r.cpu.push_kind == pic_pkg::PUSH_PCH)
        ##MC_C (st_r.cpu.push_valid && st_r.cpu.push_kind == pic_pkg::PUSH_PCL);
  endproperty
  a_push_order: assert property (p_push_order)
    else $error("push sequence out of order or timing");

  property p_save_mask;
    @(posedge clock) disable iff (!resetn)
      st_r.cpu.accept |-> (!mask_q && st_r.cpu.push_mask == $past(mask_q));
  endproperty
  a_save_mask: assert property (p_save_mask)
    else $error("master mask not saved and cleared on acceptance");

  property p_no_sw_set;
    @(posedge clock) disable iff (!resetn)
      (pend_q & ~$past(pend_q) & ~$past(set_q)) == 16'h0000;
  endproperty
  a_no_sw_set: assert property (p_no_sw_set)
    else $error("latch rose without a source request");

  property p_vector;
    @(posedge clock) disable iff (!resetn)
      (st_r.cpu.accept && st_r.cpu.accept_idx == 4'h4) |-> st_r.cpu.vector == 16'hFFF6;
  endproperty
  a_vector: assert property (p_vector)
    else $error("level 4 vector wrong");

endmodule

// ==== rtl/pic_prio.sv ====
/*
  Priority resolver: picks the winning request from pending latches and enables.
  Assumes purely combinational use by the controller on the same clock.
*/
`timescale 1ns/1ps
module pic_prio (
  // Latches, enables and the soft trap request
  input  wire logic [15:0] pend,
  input  wire logic [15:0] en,
  input  wire logic        ext0_en,
  input  wire logic        soft_req,
  // Winner
  output logic             valid,
  output logic [3:0]       idx
);

  always_comb begin
    valid = 1'b0;
    idx   = 4'h0;
    // Walk from lowest priority so the highest enabled level is left standing
    for (int i = pic_pkg::LVL_LAST; i >= pic_pkg::LVL_FIRST; i--) begin
      if (en[pic_pkg::MASK_BIT] && en[i] && pend[i] &&
          (i != pic_pkg::LVL_FIRST || ext0_en)) begin
        valid = 1'b1;
        idx   = 4'(i);
      end
    end
    // Non-maskable sources override any maskable winner
    if (pend[pic_pkg::WDOG_IDX]) begin
      valid = 1'b1;
      idx   = 4'(pic_pkg::WDOG_IDX);
    end
    if (pend[pic_pkg::TRAP_IDX]) begin
      valid = 1'b1;
      idx   = 4'(pic_pkg::TRAP_IDX);
    end
    if (soft_req) begin
      valid = 1'b1;
      idx   = 4'(pic_pkg::SOFT_IDX);
    end
  end

endmodule

// ==== shared/pic_pkg.sv ====
/*
  Package of the prioritized interrupt controller: register indexes, field
  positions, reset values, timing counts, carrier structs and the vector function.
  Assumes it is compiled before every file of the controller.
*/
package pic_pkg;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  localparam int unsigned AV_AW          = 9;
  // Register indexes; the byte address is four times the index
  localparam logic [6:0]  IDX_EN_LO      = 7'h3A;
  localparam logic [6:0]  IDX_EN_HI      = 7'h3B;
  localparam logic [6:0]  IDX_PEND_LO    = 7'h3C;
  localparam logic [6:0]  IDX_PEND_HI    = 7'h3D;
  localparam logic [6:0]  IDX_SELECT     = 7'h40;
  localparam logic [6:0]  IDX_STATUS     = 7'h41;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned MASK_BIT       = 0;
  localparam int unsigned SOFT_IDX       = 1;
  localparam int unsigned TRAP_IDX       = 2;
  localparam int unsigned WDOG_IDX       = 3;
  localparam int unsigned LVL_FIRST      = 4;
  localparam int unsigned LVL_LAST       = 15;
  localparam int unsigned SEL_L9         = 0;
  localparam int unsigned SEL_L14        = 1;
  localparam int unsigned SEL_L15        = 2;
  localparam int unsigned SEL_EXT0       = 3;
  localparam logic [7:0]  EN_LO_WMASK    = 8'hF1;
  localparam logic [15:0] PEND_MASK      = 16'hFFFC;
  localparam logic [15:0] EN_RESET       = 16'h0000;
  localparam logic [15:0] PEND_RESET     = 16'h0000;
  localparam logic [3:0]  SEL_RESET      = 4'h0;
  // Vector of index i is VEC_BASE minus two times i
  localparam logic [15:0] VEC_BASE       = 16'hFFFE;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned ACC_MCYC       = 8;
  localparam int unsigned PUSH_COUNT     = 3;
  localparam int unsigned MC_CLKS_DEF    = 4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic {ST_IDLE, ST_ACCEPT} pic_fsm_type;
  typedef enum logic [1:0] {PUSH_PSW, PUSH_PCH, PUSH_PCL} pic_push_type;

  typedef struct packed {
    logic ext0;
    logic ext1;
    logic timebase;
    logic ext2;
    logic timer1;
    logic uart_rx;
    logic sync_serial;
    logic uart_tx;
    logic timer4;
    logic timer6;
    logic converter_done;
    logic ext3;
    logic timer3;
    logic ext5;
    logic timer5;
    logic address_trap;
    logic watchdog_irq;
  } pic_src_type;

  typedef struct packed {
    logic              read;
    logic              write;
    logic [AV_AW-1:0]  address;
    logic [31:0]       writedata;
    logic [3:0]        byteenable;
  } pic_av_req_type;

  typedef struct packed {
    logic        waitrequest;
    logic [31:0] readdata;
  } pic_av_rsp_type;

  typedef struct packed {
    logic sample;
    logic soft_trap;
    logic bad_opcode_trap;
    logic unmask_instr;
    logic mask_off_instr;
    logic ret_restore;
    logic ret_mask;
  } pic_cpu_in_type;

  typedef struct packed {
    logic         irq_req;
    logic         accept;
    logic [3:0]   accept_idx;
    logic         soft_ack;
    logic         push_valid;
    pic_push_type push_kind;
    logic         push_mask;
    logic         vec_valid;
    logic [15:0]  vector;
  } pic_cpu_out_type;

  typedef struct packed {
    pic_fsm_type     fsm;
    logic [7:0]      sub;
    logic [2:0]      mcyc;
    logic [15:0]     en;
    logic [15:0]     pend;
    logic [3:0]      sel;
    logic            saved_mask;
    pic_av_rsp_type  av;
    pic_cpu_out_type cpu;
  } pic_state_type;

  function automatic logic [15:0] pic_vector(input logic [3:0] idx);
    return VEC_BASE - {11'h000, idx, 1'b0};
  endfunction

endpackage
